// ### wrs_consts.vh
// constants for the warm reset sequencer
`ifndef WRS_CONSTS_VH
`define WRS_CONSTS_VH
`define WRS_CLK_PERIOD_NS 40
`define WRS_DRIVE_CYCLES 4000
`define WRS_RELEASE_WAIT_CYCLES 4000
`define WRS_BOOT_CS_DELAY_CYCLES 16
`define WRS_CNT_W 12
`define WRS_DATA_W 8
`define WRS_ADDR_W 16
`define WRS_CFG_W 16
`define WRS_PLL_MULT_LSB 0
`define WRS_PLL_MULT_W 3
`define WRS_CFG_RESET 16'h0000
`define WRS_ST_RUN 3'h0
`define WRS_ST_DRIVE 3'h1
`define WRS_ST_WAIT 3'h2
`define WRS_ST_SAMPLE 3'h3
`define WRS_ST_BOOT 3'h4
`endif

// ### wrs_warm_reset_sequencer.v
// warm reset handshake sequencer for the external memory bus
`include "wrs_consts.vh"
module wrs_warm_reset_sequencer (
  input  wire                     clock_in,
  input  wire                     resetn_in,
  input  wire                     pipeline_clock_in,
  input  wire                     warm_reset_pin_n_in,
  output wire                     warm_reset_pin_n_out,
  output wire                     warm_reset_pin_n_oe_out,
  input  wire [`WRS_CFG_W-1:0]    ext_address_bus_in,
  input  wire [`WRS_ADDR_W-1:0]   core_address_in,
  input  wire [`WRS_DATA_W-1:0]   core_data_in,
  input  wire                     core_data_drive_in,
  input  wire                     core_strobes_in,
  input  wire                     core_boot_cs_in,
  output wire [`WRS_ADDR_W-1:0]   ext_address_bus_out,
  output wire                     ext_address_bus_oe_out,
  output wire [`WRS_DATA_W-1:0]   ext_data_bus_out,
  output wire                     ext_data_bus_oe_out,
  output wire                     mem_strobes_en_out,
  output wire                     boot_chip_select_n_out,
  output wire                     warm_reset_active_out,
  output wire                     soft_reset_out,
  output wire [`WRS_PLL_MULT_W-1:0] pll_mult_out,
  output wire                     internal_bus_clock_en_out
);

  reg [2:0]              state_r;
  reg [2:0]              state_nxt;
  reg [`WRS_CNT_W-1:0]   cnt_r;
  reg [`WRS_CNT_W-1:0]   cnt_nxt;
  reg                    sync1_r;
  reg                    sync2_r;
  reg                    pin_drive_r;
  reg                    data_oe_r;
  reg                    strobe_en_r;
  reg                    boot_cs_en_r;
  reg                    soft_reset_r;
  reg [`WRS_DATA_W-1:0]  data_r;
  reg [`WRS_ADDR_W-1:0]  addr_r;
  reg                    cold_done_r;
  reg [`WRS_CFG_W-1:0]   cfg_r;
  reg                    half_r;

  // state codes of the sequence machine
  localparam [2:0] ST_RUN    = 3'h0; // normal bus operation
  localparam [2:0] ST_DRIVE  = 3'h1; // device pulls the pin low
  localparam [2:0] ST_WAIT   = 3'h2; // pin ignored after release
  localparam [2:0] ST_SAMPLE = 3'h3; // waiting for the agent release
  localparam [2:0] ST_BOOT   = 3'h4; // boot chip select held off

  // last count of each timed phase, sized to the counter
  localparam [`WRS_CNT_W-1:0] DRIVE_LAST = `WRS_DRIVE_CYCLES - 1;
  localparam [`WRS_CNT_W-1:0] WAIT_LAST  = `WRS_RELEASE_WAIT_CYCLES - 1;
  localparam [`WRS_CNT_W-1:0] BOOT_LAST  = `WRS_BOOT_CS_DELAY_CYCLES - 1;

  // phase decodes shared by the next state logic and the output flops
  wire                   drive_done;
  wire                   wait_done;
  wire                   boot_done;
  wire                   nxt_run;
  wire                   nxt_drive;
  wire                   nxt_boot;

  // two-flop synchroniser for the asynchronous pin input
  // pin synchroniser
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
    end else begin
      sync1_r <= warm_reset_pin_n_in;
      sync2_r <= sync1_r;
    end
  end

  // next state of the sequence machine
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (!sync2_r) begin
          state_nxt = ST_DRIVE;
        end
      end
      ST_DRIVE: begin
        if (drive_done) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (wait_done) begin
          state_nxt = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (sync2_r) begin
          state_nxt = ST_BOOT;
        end
      end
      ST_BOOT: begin
        if (boot_done) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  // shared phase counter, cleared at every phase change
  always @* begin
    if (state_nxt != state_r) begin
      cnt_nxt = {`WRS_CNT_W{1'b0}};
    end else if ((state_r == ST_DRIVE) ||
                 (state_r == ST_WAIT) ||
                 (state_r == ST_BOOT)) begin
      cnt_nxt = cnt_r + 1'b1;
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  // end of each timed phase
  assign drive_done = (cnt_r == DRIVE_LAST);
  assign wait_done  = (cnt_r == WAIT_LAST);
  assign boot_done  = (cnt_r == BOOT_LAST);

  // next state decodes for the output flops
  assign nxt_run    = (state_nxt == ST_RUN);
  assign nxt_drive  = (state_nxt == ST_DRIVE);
  assign nxt_boot   = (state_nxt == ST_BOOT);

  // state and counter registers
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= ST_RUN;
      cnt_r   <= {`WRS_CNT_W{1'b0}};
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // pin pull-down flop, high for the whole drive phase
  // pin drive
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_drive_r <= 1'b0;
    end else begin
      pin_drive_r <= nxt_drive;
    end
  end

  // data bus enable, only in normal operation
  // data bus enable
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      data_oe_r <= 1'b0;
    end else begin
      data_oe_r <= nxt_run & core_data_drive_in;
    end
  end

  // memory strobe gate, closed in every warm reset phase
  // strobe negation
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      strobe_en_r <= 1'b0;
    end else begin
      strobe_en_r <= nxt_run;
    end
  end

  // boot select gate, opens only after the boot delay
  // boot select gate
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      boot_cs_en_r <= 1'b0;
    end else begin
      boot_cs_en_r <= nxt_run;
    end
  end

  // soft reset request while the boot delay runs
  // soft reset window
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      soft_reset_r <= 1'b0;
    end else begin
      soft_reset_r <= nxt_boot;
    end
  end

  // data bus register, one flop per bit lane
  genvar gi;
  generate
    for (gi = 0; gi < `WRS_DATA_W; gi = gi + 1) begin : g_data
      always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
          data_r[gi] <= 1'b0;
        end else begin
          data_r[gi] <= core_data_in[gi];
        end
      end
    end
  endgenerate

  // address bus register
  // address register
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      addr_r <= 16'h0000;
    end else begin
      addr_r <= core_address_in;
    end
  end

  // marks the first edge after cold reset release
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cold_done_r <= 1'b0;
    end else begin
      cold_done_r <= 1'b1;
    end
  end

  // boot vector capture once after cold reset release
  // boot vector capture
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cfg_r <= `WRS_CFG_RESET;
    end else if (!cold_done_r) begin
      cfg_r <= ext_address_bus_in;
    end
  end

  // internal bus clock enable, every second pipeline edge
  // half rate enable
  always @(posedge pipeline_clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      half_r <= 1'b0;
    end else begin
      half_r <= ~half_r;
    end
  end

  // pin value is always low, the enable does the work
  assign warm_reset_pin_n_out      = 1'b0;

  // pin pulled low only in the drive phase
  assign warm_reset_pin_n_oe_out   = pin_drive_r;

  assign ext_address_bus_out       = addr_r;

  // address kept driven after cold reset
  assign ext_address_bus_oe_out    = cold_done_r;

  // data bus value from the core
  assign ext_data_bus_out          = data_r;

  // data bus floats in warm reset
  assign ext_data_bus_oe_out       = data_oe_r;

  assign mem_strobes_en_out        = strobe_en_r & core_strobes_in;

  // boot select held off, active low
  assign boot_chip_select_n_out    = ~(boot_cs_en_r & core_boot_cs_in);

  // sequence busy flag for the core
  assign warm_reset_active_out     = ~strobe_en_r;

  // soft reset request to the core
  assign soft_reset_out            = soft_reset_r;

  // clock multiplier field of the boot vector
  assign pll_mult_out              =
    cfg_r[`WRS_PLL_MULT_LSB +: `WRS_PLL_MULT_W];

  assign internal_bus_clock_en_out = half_r;

endmodule // wrs_warm_reset_sequencer

// ### wrs_seq_checker.sv
// assertion checker for the warm reset sequencer
module wrs_seq_checker (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic warm_reset_pin_n_in,
  input wire logic warm_reset_pin_n_oe_out,
  input wire logic ext_address_bus_oe_out,
  input wire logic ext_data_bus_oe_out,
  input wire logic mem_strobes_en_out,
  input wire logic boot_chip_select_n_out,
  input wire logic warm_reset_active_out,
  input wire logic soft_reset_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [12:0] drv_r;
  logic [12:0] wt_r;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  // cycles the pin is driven, cycles in warm reset after release
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      drv_r <= 13'h0000;
      wt_r  <= 13'h0000;
    end else begin
      drv_r <= warm_reset_pin_n_oe_out ? drv_r + 13'h0001 : 13'h0000;
      wt_r  <= (warm_reset_active_out && !warm_reset_pin_n_oe_out) ?
               wt_r + 13'h0001 : 13'h0000;
    end
  end
  sequence s_low;
    $fell(warm_reset_pin_n_in) && !warm_reset_active_out
      ##1 !warm_reset_pin_n_in;
  endsequence
  sequence s_cs_off;
    boot_chip_select_n_out [*8];
  endsequence
  a_sync_take: assert property (
    s_low |-> ##[1:3] warm_reset_pin_n_oe_out) else $error("no entry");
  a_entry_quiet: assert property ($rose(warm_reset_pin_n_oe_out) |->
    !ext_data_bus_oe_out && !mem_strobes_en_out && boot_chip_select_n_out)
    else $error("bus not quiet");
  a_drive_len: assert property (
    $fell(warm_reset_pin_n_oe_out) |-> drv_r == 13'h0FA0)
    else $error("drive length");
  a_addr_kept: assert property (
    warm_reset_active_out && $past(resetn_in) |-> ext_address_bus_oe_out)
    else $error("addr");
  a_data_off: assert property (
    warm_reset_active_out |-> !ext_data_bus_oe_out) else $error("data");
  a_wait_min: assert property (
    $rose(soft_reset_out) |-> wt_r >= 13'h0FA0) else $error("early");
  a_boot_gap: assert property (
    $rose(soft_reset_out) |-> s_cs_off ##1 s_cs_off) else $error("cs");
  a_data_back: assert property (
    $fell(warm_reset_active_out) |-> ##[0:2] ext_data_bus_oe_out)
    else $error("data not back");
endmodule // wrs_seq_checker
bind wrs_warm_reset_sequencer wrs_seq_checker u_chk (
  .clock_in(clock_in), .resetn_in(resetn_in),
  .warm_reset_pin_n_in(warm_reset_pin_n_in),
  .warm_reset_pin_n_oe_out(warm_reset_pin_n_oe_out),
  .ext_address_bus_oe_out(ext_address_bus_oe_out),
  .ext_data_bus_oe_out(ext_data_bus_oe_out),
  .mem_strobes_en_out(mem_strobes_en_out),
  .boot_chip_select_n_out(boot_chip_select_n_out),
  .warm_reset_active_out(warm_reset_active_out),
  .soft_reset_out(soft_reset_out));

// ### wrs_reset_agent.sv
// outside reset agent model on the pulled-up warm reset pin
module wrs_reset_agent (
  input  wire logic        clock_in,
  input  wire logic        pin_oe_in,
  input  wire logic        start_in,
  input  wire logic [15:0] hold_in,
  output wire logic        pin_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] left_r = 16'h0000;
  always @(negedge clock_in) begin
    if (start_in) left_r <= hold_in;
    else if (left_r != 16'h0000) left_r <= left_r - 16'h0001;
  end
  // wired low by either party, else pulled up
  assign pin_n_out = !(pin_oe_in || left_r != 16'h0000);
endmodule // wrs_reset_agent

// ### tb_top.sv
// self-checking testbench for the warm reset sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 0, resetn_in = 0, pclk = 0, start = 0;
  logic [15:0] hold = 16'h0000;
  logic [7:0] dat = 8'h00;
  logic pin, oe, po, aoe, doe, stb, cs, act, sr, ibc;
  logic [15:0] adr;
  logic [7:0] dout;
  logic [2:0] pll;
  int fail_count = 0, checked = 0, d, g;
  initial forever #20 clock_in = ~clock_in;
  initial forever #5 pclk = ~pclk;
  always @(negedge clock_in) dat <= dat + 8'h01;
  wrs_reset_agent agent (.clock_in(clock_in), .pin_oe_in(oe),
    .start_in(start), .hold_in(hold), .pin_n_out(pin));
  wrs_warm_reset_sequencer dut (.clock_in(clock_in), .resetn_in(resetn_in),
    .pipeline_clock_in(pclk), .warm_reset_pin_n_in(pin),
    .warm_reset_pin_n_out(po), .warm_reset_pin_n_oe_out(oe),
    .ext_address_bus_in(16'h0005), .core_address_in(16'h5a5a),
    .core_data_in(dat), .core_data_drive_in(1'b1), .core_strobes_in(1'b1),
    .core_boot_cs_in(1'b1), .ext_address_bus_out(adr),
    .ext_address_bus_oe_out(aoe), .ext_data_bus_out(dout),
    .ext_data_bus_oe_out(doe), .mem_strobes_en_out(stb),
    .boot_chip_select_n_out(cs), .warm_reset_active_out(act),
    .soft_reset_out(sr), .pll_mult_out(pll),
    .internal_bus_clock_en_out(ibc));
  task chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %0t ns got %h want %h", $time, s, e);
    end
  endtask
  task summarize;
    if (fail_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task t_reset;
    repeat (3) @(negedge clock_in);
    chk(16'(pll), 16'h0005);
    chk(16'({doe, aoe, stb, cs, act}), 16'h001C);
    chk(16'(dout), 16'(dat));
    @(negedge pclk) g = ibc;
    @(negedge pclk) chk(16'(ibc), 16'(!g));
    @(negedge clock_in);
  endtask
  task t_warm(input logic [15:0] h);
    hold <= h;
    start <= 1'b1;
    @(negedge clock_in);
    start <= 1'b0;
    for (d = 0; oe !== 1'b1 && d < 10; d++) @(negedge clock_in);
    chk(16'(d < 10), 16'h0001);
    chk(16'({doe, stb, cs, aoe, po}), 16'h0006);
    chk(adr, 16'h5a5a);
    for (d = 0; oe === 1'b1 && d < 5000; d++) @(negedge clock_in);
    chk(16'(d), 16'h0FA0);
    for (g = 0; sr !== 1'b1 && g < 20000; g++) @(negedge clock_in);
    chk(16'(g >= ((h > 16'h1F4A) ? h - 16'h0FAA : 16'h0FA0)), 16'h0001);
    for (d = 0; cs === 1'b1 && d < 100; d++) @(negedge clock_in);
    chk(16'(d >= 16 && d < 100), 16'h0001);
    @(negedge clock_in);
    chk(16'({doe, act, sr}), 16'h0004);
  endtask
  initial begin
    repeat (3) @(negedge clock_in);
    resetn_in <= 1'b1;
    t_reset;
    t_warm(16'h0014);
    t_warm(16'h2328);
    summarize;
  end
  initial begin
    #(40 * 40000);
    fail_count++;
    summarize;
  end
endmodule // tb_top
